// file: efs_pkg.sv
// Constants, register map and field layout of the serial command and frame stream block
package efs_pkg;

  // ----------------------------------------------------------------
  // Command word layout
  // ----------------------------------------------------------------
  localparam int          EFS_CMD_W     = 32;
  localparam int          EFS_DATA_W    = 24;
  localparam int          EFS_RW_BIT    = 31;
  localparam int          EFS_ADDR_MSB  = 30;
  localparam int          EFS_ADDR_LSB  = 24;
  localparam logic [4:0]  EFS_LAST_BIT  = 5'h1F;

  typedef logic [EFS_CMD_W-1:0]  efs_word_t;
  typedef logic [EFS_DATA_W-1:0] efs_data_t;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [6:0] EFS_IDX_ACQ   = 7'h01;
  localparam logic [6:0] EFS_IDX_PACE  = 7'h04;
  localparam logic [6:0] EFS_IDX_CMREF = 7'h05;
  localparam logic [6:0] EFS_IDX_THR   = 7'h07;
  localparam logic [6:0] EFS_IDX_TEST  = 7'h08;
  localparam logic [6:0] EFS_IDX_FRM   = 7'h0A;
  localparam logic [6:0] EFS_IDX_FILT  = 7'h0B;
  localparam logic [6:0] EFS_IDX_PMEAS = 7'h1A;
  localparam logic [6:0] EFS_IDX_RESP  = 7'h1D;
  localparam logic [6:0] EFS_IDX_LOFF  = 7'h1E;
  localparam logic [6:0] EFS_IDX_ECG0  = 7'h11;
  localparam logic [6:0] EFS_IDX_HDR   = 7'h40;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam efs_data_t  EFS_RST_CTL   = 24'h000000;
  localparam efs_data_t  EFS_RST_THR   = 24'h242424;
  localparam efs_data_t  EFS_RST_HDR   = 24'h800000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EFS_ACQ_PWR    = 1;
  localparam int EFS_ACQ_CNV    = 2;
  localparam int EFS_ACQ_GANG   = 4;
  localparam int EFS_ACQ_MASTER = 5;
  localparam int EFS_ACQ_CLKIN  = 6;
  localparam int EFS_ACQ_DIFF   = 10;
  localparam int EFS_PACE_EN    = 0;
  localparam int EFS_PACE_LEAD  = 4;
  localparam int EFS_PACE_WFLT  = 10;
  localparam int EFS_PACE_VFLT  = 11;
  localparam int EFS_FRM_ELEC   = 4;
  localparam int EFS_FRM_ALWAYS = 9;
  localparam int EFS_FRM_DLOFF  = 11;
  localparam int EFS_FRM_DRESP  = 13;
  localparam int EFS_FRM_DPACE  = 14;
  localparam int EFS_FRM_DECG   = 21;
  localparam int EFS_HDR_MARK   = 31;
  localparam int EFS_HDR_RDY    = 30;
  localparam int EFS_HDR_PACE   = 27;

  // ----------------------------------------------------------------
  // Frame slots: header, three ECG, pace, respiration, lead-off
  // ----------------------------------------------------------------
  localparam logic [2:0] EFS_SLOT_HDR  = 3'h0;
  localparam logic [2:0] EFS_SLOT_PACE = 3'h4;
  localparam logic [2:0] EFS_SLOT_RESP = 3'h5;
  localparam logic [2:0] EFS_SLOT_LOFF = 3'h6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int EFS_CLK_MHZ   = 50;
  localparam int EFS_FRAME_NS  = 500000;
  localparam int EFS_FRAME_CYC = EFS_FRAME_NS * EFS_CLK_MHZ / 1000;

  typedef enum logic {FS_IDLE, FS_SEND} efs_frm_e;

endpackage : efs_pkg

// file: efs_buf_if.sv
// Valid/ready channel between frame builder, word buffer and serial shifter
interface efs_buf_if;
  import efs_pkg::*;
  logic      valid;
  logic      ready;
  efs_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : efs_buf_if

// file: efs_fifo2.sv
// Two-entry word buffer with valid/ready on both sides
module efs_fifo2
  import efs_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rstn,
  efs_buf_if.snk    wr,
  efs_buf_if.src    rd
);

  efs_word_t  mem_q [2];
  logic       wp_q;
  logic       rp_q;
  logic [1:0] cnt_q;
  wire        push = wr.valid && wr.ready;
  wire        pop  = rd.valid && rd.ready;

  assign wr.ready = (cnt_q != 2'h2);
  assign rd.valid = (cnt_q != 2'h0);
  assign rd.data  = mem_q[rp_q];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

endmodule : efs_fifo2

// file: efs_top.sv
// Serial command port, control registers and frame streamer of the ECG front end
// Notes on behaviour
// RULE1 - A command is 32 bits: write flag on top, 7-bit register address, 24 data bits.
// RULE2 - A read of the frame header address with zero data starts the frame stream on SDO.
// RULE3 - The host keeps clocking SCLK so frame_header_read leave at the configured packet rate.
// RULE4 - A valid pace pulse sets header pace flags and is reported in the pace measurement word.
// RULE5 - The pace amplitude threshold resets to 0x242424, 1.98 mV over gain for each instance.
// RULE6 - Pace control holds three enables, a lead select each, a width filter and validation.
// RULE7 - Frame control picks which words form a frame, so frame length can differ per device.
// RULE8 - Frame control can make frame_header_read go out whether or not new data is ready.
// RULE9 - A gang slave in conversion mode waits for the master's sync edge before converting.
// RULE10 - A gang master raises the sync pin when it enters conversion mode.
// RULE11 - A gang slave runs from the clock input, a master from the crystal input. The code selects the clock input for a slave only when EFS_ACQ_CLKIN is set.
// RULE12 - Differential input selects analog lead mode instead of electrode format.
// RULE13 - With electrode format output the host computes leads itself.
// RULE14 - In a ganged pair the host starts the stream on both devices separately.
// RULE15 - A nonzero command during streaming stops the stream and conversions, then is processed. The code leaves the stream off after a frame header read.
// RULE16 - Command bits enter MSB first, one per SCLK rising edge, 32 per word while selected.
module efs_top
  import efs_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = EFS_FRAME_CYC
)(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  input  wire logic        sync_gang_in,
  output logic             sync_gang_out,
  input  wire logic        sample_valid,
  input  wire logic [71:0] ecg_samples,
  input  wire logic [23:0] resp_sample,
  input  wire logic [23:0] leadoff_status,
  input  wire logic [2:0]  pace_detect,
  input  wire logic [23:0] pace_meas,
  output logic             converting,
  output logic             clk_in_select,
  output logic             analog_lead_mode,
  output logic             electrode_format,
  output logic [23:0]      pace_control,
  output logic [23:0]      pace_amplitude_threshold,
  output logic [23:0]      common_mode_reference_control,
  output logic [23:0]      test_signal_control,
  output logic [23:0]      filter_control
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic word_en(input logic [2:0] idx, input efs_data_t frm);
    logic en;
    en = 1'b1;
    if (idx >= 3'h1 && idx <= 3'h3) begin
      en = ~frm[EFS_FRM_DECG + int'(idx) - 1];
    end else if (idx == EFS_SLOT_PACE) begin
      en = ~frm[EFS_FRM_DPACE];
    end else if (idx == EFS_SLOT_RESP) begin
      en = ~frm[EFS_FRM_DRESP];
    end else if (idx == EFS_SLOT_LOFF) begin
      en = ~frm[EFS_FRM_DLOFF];
    end
    return en;
  endfunction : word_en

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic       sclk_d3_q;
  logic       cs_d3_q;
  logic       sg_d3_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q      <= 4'h2;
      s2_q      <= 4'h2;
      sclk_d3_q <= 1'b0;
      cs_d3_q   <= 1'b1;
      sg_d3_q   <= 1'b0;
    end else begin
      s1_q      <= {sync_gang_in, sdi, cs_n, sclk};
      s2_q      <= s1_q;
      sclk_d3_q <= s2_q[0];
      cs_d3_q   <= s2_q[1];
      sg_d3_q   <= s2_q[3];
    end
  end

  wire sclk_s  = s2_q[0];
  wire cs_s    = s2_q[1];
  wire sdi_s   = s2_q[2];
  wire sel     = ~cs_s;
  wire sck_ris = sel && sclk_s && !sclk_d3_q;
  wire sck_fal = sel && !sclk_s && sclk_d3_q;
  wire cs_fall = !cs_s && cs_d3_q;
  wire sg_rise = s2_q[3] && !sg_d3_q;

  // ----------------------------------------------------------------
  // Command shifter and decode
  // ----------------------------------------------------------------
  efs_word_t  rx_q;
  logic [4:0] bit_q;
  efs_word_t  out_q;
  efs_word_t  resp_q;
  logic       stream_q;

  wire efs_word_t rx_next  = {rx_q[30:0], sdi_s};  // RULE16
  wire            done     = sck_ris && (bit_q == EFS_LAST_BIT);  // RULE16
  wire            cmd_wr   = rx_next[EFS_RW_BIT];  // RULE1
  wire [6:0]      cmd_addr = rx_next[EFS_ADDR_MSB:EFS_ADDR_LSB];  // RULE1
  wire efs_data_t cmd_data = rx_next[EFS_DATA_W-1:0];  // RULE1
  wire            do_wr    = done && cmd_wr;
  wire            start_rd = done && !cmd_wr && cmd_addr == EFS_IDX_HDR
                             && cmd_data == EFS_RST_CTL;  // RULE2
  wire            brk_cmd  = done && stream_q && rx_next != '0;  // RULE15

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  efs_data_t acq_q;
  efs_data_t pace_q;
  efs_data_t cmref_q;
  efs_data_t thr_q;
  efs_data_t test_q;
  efs_data_t frm_q;
  efs_data_t filt_q;
  efs_data_t pmeas_q;
  logic [2:0] pflag_q;
  logic       newd_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acq_q   <= EFS_RST_CTL;
      pace_q  <= EFS_RST_CTL;
      cmref_q <= EFS_RST_CTL;
      thr_q   <= EFS_RST_THR;  // RULE5
      test_q  <= EFS_RST_CTL;
      frm_q   <= EFS_RST_CTL;
      filt_q  <= EFS_RST_CTL;
    end else begin
      if (brk_cmd) begin
        acq_q[EFS_ACQ_CNV] <= 1'b0;  // RULE15
      end
      if (do_wr) begin
        if (cmd_addr == EFS_IDX_ACQ) begin
          acq_q <= cmd_data;
        end else if (cmd_addr == EFS_IDX_PACE) begin
          pace_q <= cmd_data;  // RULE6
        end else if (cmd_addr == EFS_IDX_CMREF) begin
          cmref_q <= cmd_data;
        end else if (cmd_addr == EFS_IDX_THR) begin
          thr_q <= cmd_data;
        end else if (cmd_addr == EFS_IDX_TEST) begin
          test_q <= cmd_data;
        end else if (cmd_addr == EFS_IDX_FRM) begin
          frm_q <= cmd_data;  // RULE7
        end else if (cmd_addr == EFS_IDX_FILT) begin
          filt_q <= cmd_data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Gang, clock source and conversion control
  // ----------------------------------------------------------------
  logic synced_q;
  wire  gang_slave = acq_q[EFS_ACQ_GANG] && !acq_q[EFS_ACQ_MASTER];
  wire  cnv_req    = acq_q[EFS_ACQ_PWR] && acq_q[EFS_ACQ_CNV];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      synced_q      <= 1'b0;
      sync_gang_out <= 1'b0;
    end else begin
      synced_q      <= cnv_req && (synced_q || (gang_slave && sg_rise));  // RULE9
      sync_gang_out <= cnv_req && acq_q[EFS_ACQ_GANG] && acq_q[EFS_ACQ_MASTER];  // RULE10
    end
  end

  assign converting       = cnv_req && (!gang_slave || synced_q);  // RULE9
  assign clk_in_select    = gang_slave && acq_q[EFS_ACQ_CLKIN];  // RULE11
  assign analog_lead_mode = acq_q[EFS_ACQ_DIFF];  // RULE12
  assign electrode_format = !acq_q[EFS_ACQ_DIFF] && frm_q[EFS_FRM_ELEC];  // RULE12
  assign pace_control                  = pace_q;
  assign pace_amplitude_threshold      = thr_q;
  assign common_mode_reference_control = cmref_q;
  assign test_signal_control           = test_q;
  assign filter_control                = filt_q;

  // ----------------------------------------------------------------
  // Samples, pace capture and frame timer
  // ----------------------------------------------------------------
  efs_data_t  samp_q [5];
  logic [31:0] tmr_q;
  efs_frm_e   fs_q;
  logic [2:0] idx_q;
  efs_buf_if  bin ();
  efs_buf_if  bout ();

  wire [2:0] pace_hit = pace_detect & pace_q[EFS_PACE_EN +: 3];  // RULE6
  wire       hdr_push = bin.valid && bin.ready && idx_q == EFS_SLOT_HDR;
  wire       tick     = (tmr_q == FRAME_CYCLES - 1);
  wire       go       = fs_q == FS_IDLE && stream_q && converting
                        && ((sample_valid && !frm_q[EFS_FRM_ALWAYS])
                        || (tick && frm_q[EFS_FRM_ALWAYS]));  // RULE8

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pmeas_q <= EFS_RST_CTL;
      pflag_q <= 3'h0;
      newd_q  <= 1'b0;
      tmr_q   <= 32'h0;
    end else begin
      if (pace_hit != 3'h0) begin
        pmeas_q <= pace_meas;  // RULE4
      end
      pflag_q <= (hdr_push ? 3'h0 : pflag_q) | pace_hit;  // RULE4
      newd_q  <= (hdr_push ? 1'b0 : newd_q) | (sample_valid && converting);
      tmr_q   <= (!converting || tick) ? 32'h0 : tmr_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sample_valid) begin
      samp_q[0] <= ecg_samples[23:0];
      samp_q[1] <= ecg_samples[47:24];
      samp_q[2] <= ecg_samples[71:48];
      samp_q[3] <= resp_sample;
      samp_q[4] <= leadoff_status;
    end
  end

  // ----------------------------------------------------------------
  // Frame builder
  // ----------------------------------------------------------------
  wire efs_word_t hdr_word = {1'b1, newd_q, pflag_q, 27'h0};  // RULE4
  wire efs_word_t dat_word =
      (idx_q == EFS_SLOT_PACE) ? {1'b0, EFS_IDX_PMEAS, pmeas_q} :
      (idx_q == EFS_SLOT_RESP) ? {1'b0, EFS_IDX_RESP, samp_q[3]} :
      (idx_q == EFS_SLOT_LOFF) ? {1'b0, EFS_IDX_LOFF, samp_q[4]} :
      {1'b0, EFS_IDX_ECG0 + 7'(idx_q - 3'h1), samp_q[idx_q[1:0] - 2'h1]};
  wire slot_en = word_en(idx_q, frm_q);  // RULE7
  wire advance = !slot_en || bin.ready;

  assign bin.valid = fs_q == FS_SEND && slot_en;
  assign bin.data  = (idx_q == EFS_SLOT_HDR) ? hdr_word : dat_word;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fs_q  <= FS_IDLE;
      idx_q <= EFS_SLOT_HDR;
    end else begin
      case (fs_q)
        FS_IDLE: begin
          idx_q <= EFS_SLOT_HDR;
          if (go) begin
            fs_q <= FS_SEND;
          end
        end
        FS_SEND: begin
          if (advance) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == EFS_SLOT_LOFF) begin
              fs_q <= FS_IDLE;
            end
          end
        end
        default: fs_q <= FS_IDLE;
      endcase
    end
  end

  efs_fifo2 u_buf (
    .core_clk (core_clk),
    .rstn     (rstn),
    .wr       (bin),
    .rd       (bout)
  );

  // ----------------------------------------------------------------
  // Read data and output shifter
  // ----------------------------------------------------------------
  wire efs_data_t rd_data =
      (cmd_addr == EFS_IDX_ACQ)   ? acq_q   :
      (cmd_addr == EFS_IDX_PACE)  ? pace_q  :
      (cmd_addr == EFS_IDX_CMREF) ? cmref_q :
      (cmd_addr == EFS_IDX_THR)   ? thr_q   :
      (cmd_addr == EFS_IDX_TEST)  ? test_q  :
      (cmd_addr == EFS_IDX_FRM)   ? frm_q   :
      (cmd_addr == EFS_IDX_FILT)  ? filt_q  :
      (cmd_addr == EFS_IDX_PMEAS) ? pmeas_q :
      (cmd_addr == EFS_IDX_HDR)   ? EFS_RST_HDR : EFS_RST_CTL;
  wire efs_word_t resp_d = cmd_wr ? '0 : {1'b0, cmd_addr, rd_data};
  wire            load   = done || cs_fall;
  wire            take   = stream_q && bout.valid;
  wire efs_word_t load_w = take ? bout.data : (done ? resp_d : resp_q);

  assign bout.ready = load && stream_q;
  assign sdo        = out_q[31];  // RULE16
  assign sdo_oe     = sel;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_q     <= '0;
      bit_q    <= 5'h0;
      out_q    <= '0;
      resp_q   <= '0;
      stream_q <= 1'b0;
    end else begin
      if (!sel) begin
        bit_q <= 5'h0;
      end else if (sck_ris) begin
        rx_q  <= rx_next;
        bit_q <= bit_q + 5'h1;  // RULE16
      end
      if (load) begin
        out_q <= load_w;
      end else if (sck_fal && bit_q != 5'h0) begin
        out_q <= {out_q[30:0], 1'b0};  // RULE16
      end
      if (done) begin
        resp_q <= resp_d;
      end
      if (brk_cmd) begin
        stream_q <= 1'b0;  // RULE15
      end else if (start_rd) begin
        stream_q <= 1'b1;  // RULE2
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  logic thr_wr_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      thr_wr_q <= 1'b0;
    end else if (do_wr && cmd_addr == EFS_IDX_THR) begin
      thr_wr_q <= 1'b1;
    end
  end

  sequence s_frame_write;
    do_wr && cmd_addr == EFS_IDX_FRM;
  endsequence
  sequence s_stream_start;
    start_rd && !stream_q;
  endsequence

  a_cmd_write_frm: assert property (s_frame_write |=> frm_q == $past(rx_next[23:0])) // RULE1
    else $error("frame control not loaded from command data");
  a_stream_start_rd: assert property (s_stream_start |=> stream_q) // RULE2
    else $error("frame header read did not start stream");
  a_pace_flag_set: assert property ((pace_hit != 3'h0) |=>
      ((pflag_q & $past(pace_hit)) == $past(pace_hit)) && pmeas_q == $past(pace_meas)) // RULE4
    else $error("pace event not recorded");
  a_thr_reset_val: assert property (!thr_wr_q |-> thr_q == 24'h242424) // RULE5
    else $error("pace threshold lost its reset value");
  a_pace_dis_ignore: assert property ((pflag_q == 3'h0 && pace_hit == 3'h0) |=>
      pflag_q == 3'h0) // RULE6
    else $error("disabled pace instance set a flag");
  a_frame_word_sel: assert property (bin.valid |-> word_en(idx_q, frm_q)) // RULE7
    else $error("disabled frame word pushed");
  a_always_send_go: assert property ((fs_q == FS_IDLE && stream_q && converting && tick
      && frm_q[EFS_FRM_ALWAYS]) |=> fs_q == FS_SEND) // RULE8
    else $error("always-send frame not started");
  a_slave_hold_cnv: assert property ((gang_slave && !synced_q) |-> !converting) // RULE9
    else $error("gang slave converted before sync");
  a_master_sync_edge: assert property ($rose(cnv_req) && acq_q[EFS_ACQ_GANG]
      && acq_q[EFS_ACQ_MASTER] |=> $rose(sync_gang_out)) // RULE10
    else $error("gang master gave no sync edge");
  a_cmd_break_stop: assert property (brk_cmd && !(do_wr && cmd_addr == EFS_IDX_ACQ)
      |=> !stream_q && !converting) // RULE15
    else $error("command during stream did not stop it");
  a_msb_first_out: assert property ((sck_fal && bit_q != 5'h0 && !load) |=>
      out_q == {$past(out_q[30:0]), 1'b0}) // RULE16
    else $error("output word not shifted msb first");

endmodule : efs_top

// file: efs_host_model.sv
// Host serial master model driving the command port and collecting SDO
module efs_host_model
  import efs_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sdo,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b1;
  end

  task automatic select_dev;
    cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : select_dev

  // One word both ways, 160 ns per bit, sclk idles low
  task automatic xfer(input efs_word_t tx, output efs_word_t rx);
    for (int i = EFS_CMD_W - 1; i >= 0; i--) begin
      sdi <= tx[i];
      repeat (4) @(posedge core_clk);
      rx[i] = sdo;
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      sclk <= 1'b0;
    end
    @(posedge core_clk);
  endtask : xfer
endmodule : efs_host_model

// file: efs_top_tb.sv
// Self-checking bench for the serial command and frame stream block
module efs_top_tb
  import efs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned FRM = 2000;
  logic core_clk, rstn, sclk, cs_n, sdi, sdo, sdo_oe;
  logic sync_gang_in, sync_gang_out, sample_valid, converting, clk_in_select;
  logic analog_lead_mode, electrode_format;
  logic [71:0] ecg_samples;
  logic [23:0] resp_sample, leadoff_status, pace_meas;
  logic [23:0] pace_control, pace_amplitude_threshold, common_mode_reference_control;
  logic [23:0] test_signal_control, filter_control;
  logic [2:0]  pace_detect;
  efs_word_t   w;
  int          fails, samples_checked, cycles;

  efs_top #(.FRAME_CYCLES(FRM)) dut_u (.*);
  efs_host_model host_u (.core_clk(core_clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input efs_word_t c);
    host_u.xfer(c, w);
    repeat (4) @(posedge core_clk);
  endtask : wr

  // Reply to a read comes in the following word; zero filler holds SDI low
  task automatic rd(input logic [6:0] a, input efs_data_t d);
    host_u.xfer({1'b0, a, d}, w);
    host_u.xfer(32'h0, w);
  endtask : rd

  task automatic t_regs;
    chk(pace_amplitude_threshold, EFS_RST_THR);
    chk(sdo_oe, 1'b1);
    wr(32'h8500000B);
    wr(32'h88E0000D);
    wr(32'h8B000008);
    wr(32'h84000F8F);
    chk(common_mode_reference_control, 24'h00000B);
    chk(test_signal_control, 24'hE0000D);
    chk(filter_control, 24'h000008);
    chk(pace_control, 24'h000F8F);
    rd(EFS_IDX_PACE, 24'h0);
    chk(w, 32'h04000F8F);
    rd(EFS_IDX_THR, 24'h0);
    chk(w, 32'h07242424);
    wr(32'hC0123456);
    rd(7'h7F, 24'h0);
    chk(w, 32'h7F000000);
    rd(EFS_IDX_HDR, 24'h000001);
    chk(w, 32'h40800000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_gang;
    wr(32'h81E004BE);
    chk(sync_gang_out, 1'b1);
    chk(clk_in_select, 1'b0);
    chk(analog_lead_mode, 1'b1);
    wr(32'h81E000DE);
    chk(converting, 1'b0);
    chk(clk_in_select, 1'b1);
    sync_gang_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(converting, 1'b1);
    sync_gang_in <= 1'b0;
    $display("test gang done");
  endtask : t_gang

  task automatic t_stream;
    efs_word_t exp_q[6];
    exp_q = '{32'h11111111, 32'h12222222, 32'h13333333,
              32'h1A00ABCD, 32'h1D5A5A5A, 32'h1E0000C3};
    wr(32'h8A1F9410);
    wr(32'h81E000AE);
    chk(electrode_format, 1'b1);
    chk(converting, 1'b1);
    host_u.xfer(32'h40000000, w);
    sample_valid <= 1'b1;
    pace_detect  <= 3'b101;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    pace_detect  <= 3'b000;
    for (int i = 0; i < 10; i++) begin
      host_u.xfer(32'h0, w);
      if (w[31] === 1'b1) break;
    end
    chk(w, 32'hE8000000);
    for (int i = 0; i < 6; i++) begin
      host_u.xfer(32'h0, w);
      chk(w, exp_q[i]);
    end
    $display("test stream done");
  endtask : t_stream

  task automatic t_always;
    host_u.xfer(32'h8A1F9610, w);
    repeat (4) @(posedge core_clk);
    chk(converting, 1'b0);
    wr(32'h81E000AE);
    host_u.xfer(32'h40000000, w);
    for (int i = 0; i < 20; i++) begin
      host_u.xfer(32'h0, w);
      if (w[31] === 1'b1) break;
    end
    chk(w, 32'h80000000);
    $display("test always done");
  endtask : t_always

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    sync_gang_in = 1'b0;
    sample_valid = 1'b0;
    pace_detect = 3'b000;
    ecg_samples = 72'h333333_222222_111111;
    resp_sample = 24'h5A5A5A;
    leadoff_status = 24'h0000C3;
    pace_meas = 24'h00ABCD;
    repeat (16) @(posedge core_clk);
    chk(sdo_oe, 1'b0);
    chk(converting, 1'b0);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    host_u.select_dev();
    t_regs();
    t_gang();
    t_stream();
    t_always();
    give_verdict();
  end
endmodule : efs_top_tb
